/* File: hw/handler_pkg.sv */
// shared constants for the handler trigger and relay output block
package handler_pkg;

	// ------------------------------------------------------------
	// clock and timing
	// ------------------------------------------------------------
	localparam int CLK_HZ        = 125_000_000;
	localparam int PULSE_TIME_MS = 5;
	localparam int PULSE_CYC     = PULSE_TIME_MS * (CLK_HZ / 1000);
	localparam int DELAY_MAX_S   = 60;
	localparam int CYC_W         = 33;
	localparam logic [CYC_W-1:0] DELAY_MAX_CYC = CYC_W'(64'(DELAY_MAX_S) * 64'(CLK_HZ));

	// ------------------------------------------------------------
	// register indices, byte address is four times the index
	// ------------------------------------------------------------
	localparam logic [7:0] IDX_TRIGGER_SOURCE_SELECT_SRC = 8'h11;
	localparam logic [7:0] IDX_DELAY    = 8'h12;
	localparam logic [7:0] IDX_ONE_SHOT_BUS_TRIGGER = 8'h13;
	localparam logic [7:0] IDX_CH_MODE  = 8'h14;
	localparam logic [7:0] IDX_STATUS   = 8'h15;

	// ------------------------------------------------------------
	// field values and layouts
	// ------------------------------------------------------------
	localparam logic [7:0]  SRC_INT      = 8'h00;
	localparam logic [7:0]  SRC_MAN      = 8'h01;
	localparam logic [7:0]  SRC_EXT      = 8'h02;
	localparam logic [7:0]  SRC_BUS      = 8'h03;
	localparam logic [7:0]  ONE_SHOT_BUS_TRIGGER_VAL = 8'h00;
	localparam int          MODE_W       = 3;
	localparam logic [2:0]  MODE_OFF     = 3'h0;
	localparam logic [2:0]  MODE_FAIL_ST = 3'h1;
	localparam logic [2:0]  MODE_PASS_ST = 3'h2;
	localparam logic [2:0]  MODE_FAIL_PL = 3'h3;
	localparam logic [2:0]  MODE_PASS_PL = 3'h4;
	localparam logic [7:0]  TRIGGER_SOURCE_SELECT_SRC_RST = 8'h00;
	localparam logic [31:0] DELAY_RST    = 32'h0000_0000;
	localparam int          ST_BUSY_BIT  = 0;
	localparam int          ST_RELAY_LSB = 4;
	localparam int          ST_RES_LSB   = 8;
	localparam int          ST_CNT_LSB   = 16;
	localparam int          CNT_W        = 16;
	localparam logic [7:0]  FLT_ONE_LSB  = 8'd150;

	typedef enum logic [1:0] {ST_IDLE, ST_DELAY, ST_MEAS} state_t;

endpackage

/* File: hw/conv_if.sv */
// carrier between the trigger control and the delay converter
`timescale 1ns/1ps
interface conv_if
	import handler_pkg::*;
	();
	logic [31:0]      fval;
	logic [CYC_W-1:0] cyc;
	modport src  (output fval, input cyc);
	modport conv (input fval, output cyc);
endinterface

/* File: hw/delay_convert.sv */
// converts the delay float in seconds to a clock cycle count
`timescale 1ns/1ps
module delay_convert
	import handler_pkg::*;
#(
	parameter logic [CYC_W-1:0] MAX_CYC = DELAY_MAX_CYC
)
(
	// clock and reset
	input  wire logic i_clk,
	input  wire logic i_rst,
	// float in, cycles out
	conv_if.conv      cv
);

	logic [CYC_W-1:0] cyc_r;
	logic [CYC_W-1:0] cyc_nxt;
	logic [63:0]      prod;
	logic [63:0]      shifted;
	logic [7:0]       ex;

	// ------------------------------------------------------------
	// seconds times clock rate, scaled by exponent
	// ------------------------------------------------------------
	always_comb
	begin
		ex      = cv.fval[30:23];
		prod    = 64'({1'b1, cv.fval[22:0]}) * 64'(CLK_HZ);
		shifted = '0;
		cyc_nxt = '0;
		if (cv.fval[31] || ex == 8'h00)
			cyc_nxt = '0;
		else if (ex > FLT_ONE_LSB)
			cyc_nxt = MAX_CYC;
		else if ((FLT_ONE_LSB - ex) < 8'd64)
		begin
			shifted = prod >> (FLT_ONE_LSB - ex);
			cyc_nxt = (shifted > 64'(MAX_CYC)) ? MAX_CYC : shifted[CYC_W-1:0];
		end
	end

	always_ff @(posedge i_clk)
	begin
		if (i_rst)
			cyc_r <= '0;
		else
			cyc_r <= cyc_nxt;
	end

	assign cv.cyc = cyc_r;

endmodule

/* File: hw/handler_trigger_output.sv */
// trigger selection, delay, measurement start and relay channels
//
// Register access over AHB-Lite was chosen for this implementation.
`timescale 1ns/1ps
module handler_trigger_output
	import handler_pkg::*;
#(
	parameter int               CH_COUNT         = 4,
	parameter int               PULSE_CYCLES     = PULSE_CYC,
	parameter logic [CYC_W-1:0] DELAY_MAX_CYCLES = DELAY_MAX_CYC
)
(
	// clock and reset
	input  wire logic                I_MCLK,
	input  wire logic                I_SRST,
	// ahb-lite slave
	input  wire logic                I_HSEL,
	input  wire logic [31:0]         I_HADDR,
	input  wire logic [1:0]          I_HTRANS,
	input  wire logic                I_HWRITE,
	input  wire logic [2:0]          I_HSIZE,
	input  wire logic [31:0]         I_HWDATA,
	input  wire logic                I_HREADY,
	output logic                     O_HREADYOUT,
	output logic [31:0]              O_HRDATA,
	output logic                     O_HRESP,
	// handler pins
	input  wire logic                I_EXTERNAL_TRIGGER_N,
	input  wire logic                I_MANUAL_KEY,
	output logic [CH_COUNT-1:0]      O_OUTPUT_CHANNEL_1_TO_4,
	// measurement engine
	output logic                     O_MEAS_START,
	input  wire logic                I_MEAS_DONE,
	input  wire logic [CH_COUNT-1:0] I_CMP_PASS,
	output logic                     O_BUSY
);

	localparam int PW = $clog2(PULSE_CYCLES + 1);

	generate
		if (CH_COUNT < 1 || CH_COUNT > 4)
			$error("channel count must be 1 to 4");
		if (PULSE_CYCLES < 1)
			$error("pulse length must be at least one cycle");
	endgenerate

	// ------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------
	logic [7:0]               src_r, src_nxt;
	logic [31:0]              delay_r, delay_nxt;
	logic [MODE_W*CH_COUNT-1:0] mode_r, mode_nxt;
	logic                     wr_pend_r, wr_pend_nxt;
	logic [7:0]               wr_idx_r, wr_idx_nxt;
	logic [31:0]              rdata_r, rdata_nxt;
	logic                     ready_r, resp_r;
	logic                     take, hit;
	logic [7:0]               idx;
	logic                     one_shot_bus_trigger;
	logic                     ext_s1_r, ext_s2_r, ext_s3_r;
	logic                     key_s1_r, key_s2_r, key_s3_r;
	logic                     ext_fall, key_rise, trigger_source_select;
	state_t                   state_r, state_nxt;
	logic [CYC_W-1:0]         dcnt_r, dcnt_nxt;
	logic                     start_r, start_nxt;
	logic [CH_COUNT-1:0]      res_r, res_nxt;
	logic [CNT_W-1:0]         mcnt_r, mcnt_nxt;
	logic                     done_evt;
	logic                     busy_r, busy_nxt;
	logic                     relay_r [CH_COUNT];
	logic [PW-1:0]            pcnt_r [CH_COUNT];
	logic [CH_COUNT-1:0]      relay_vec;
	logic [31:0]              status;

	conv_if cv ();

	assign cv.fval = delay_r;

	delay_convert #(
		.MAX_CYC (DELAY_MAX_CYCLES)
	) u_conv (
		.i_clk (I_MCLK),
		.i_rst (I_SRST),
		.cv    (cv)
	);

	// ------------------------------------------------------------
	// bus slave and registers
	// ------------------------------------------------------------
	assign take     = I_HSEL && I_HREADY && I_HTRANS[1];
	assign idx      = I_HADDR[9:2];
	assign hit      = (I_HADDR[31:10] == 22'h0) && (I_HADDR[1:0] == 2'h0);
	assign one_shot_bus_trigger = wr_pend_r && (wr_idx_r == IDX_ONE_SHOT_BUS_TRIGGER)
		&& (I_HWDATA[7:0] == ONE_SHOT_BUS_TRIGGER_VAL);

	always_comb
	begin
		status                            = '0;
		status[ST_BUSY_BIT]               = busy_r;
		status[ST_RELAY_LSB +: CH_COUNT]  = relay_vec;
		status[ST_RES_LSB +: CH_COUNT]    = res_r;
		status[ST_CNT_LSB +: CNT_W]       = mcnt_r;
		src_nxt     = src_r;
		delay_nxt   = delay_r;
		mode_nxt    = mode_r;
		wr_pend_nxt = take && I_HWRITE && hit && (I_HSIZE == 3'h2);
		wr_idx_nxt  = take ? idx : wr_idx_r;
		rdata_nxt   = rdata_r;
		if (wr_pend_r)
		begin
			unique case (wr_idx_r)
				// source select code
				IDX_TRIGGER_SOURCE_SELECT_SRC: src_nxt = I_HWDATA[7:0];
				// float delay word
				IDX_DELAY:    delay_nxt = I_HWDATA;
				IDX_CH_MODE:  mode_nxt = I_HWDATA[MODE_W*CH_COUNT-1:0];
				default:      ;
			endcase
		end
		if (take && !I_HWRITE)
		begin
			rdata_nxt = 32'h0000_0000;
			if (hit)
			begin
				unique case (idx)
					IDX_TRIGGER_SOURCE_SELECT_SRC: rdata_nxt = {24'h0, src_nxt};
					IDX_DELAY:    rdata_nxt = delay_nxt;
					IDX_CH_MODE:  rdata_nxt = 32'(mode_nxt);
					IDX_STATUS:   rdata_nxt = status;
					default:      rdata_nxt = 32'h0000_0000;
				endcase
			end
		end
	end

	always_ff @(posedge I_MCLK)
	begin
		if (I_SRST)
		begin
			src_r     <= TRIGGER_SOURCE_SELECT_SRC_RST;
			delay_r   <= DELAY_RST;
			mode_r    <= '0;
			wr_pend_r <= 1'b0;
			wr_idx_r  <= 8'h00;
			rdata_r   <= 32'h0000_0000;
			ready_r   <= 1'b1;
			resp_r    <= 1'b0;
		end
		else
		begin
			src_r     <= src_nxt;
			delay_r   <= delay_nxt;
			mode_r    <= mode_nxt;
			wr_pend_r <= wr_pend_nxt;
			wr_idx_r  <= wr_idx_nxt;
			rdata_r   <= rdata_nxt;
			ready_r   <= 1'b1;
			resp_r    <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// pin synchronisers and trigger select
	// ------------------------------------------------------------
	always_ff @(posedge I_MCLK)
	begin
		if (I_SRST)
		begin
			ext_s1_r <= 1'b1;
			ext_s2_r <= 1'b1;
			ext_s3_r <= 1'b1;
			key_s1_r <= 1'b0;
			key_s2_r <= 1'b0;
			key_s3_r <= 1'b0;
		end
		else
		begin
			ext_s1_r <= I_EXTERNAL_TRIGGER_N;
			ext_s2_r <= ext_s1_r;
			ext_s3_r <= ext_s2_r;
			key_s1_r <= I_MANUAL_KEY;
			key_s2_r <= key_s1_r;
			key_s3_r <= key_s2_r;
		end
	end

	assign ext_fall = ext_s3_r && !ext_s2_r;
	assign key_rise = key_s2_r && !key_s3_r;
	assign trigger_source_select = (src_r == SRC_INT) || (key_rise && src_r == SRC_MAN)
		|| (ext_fall && (src_r == SRC_EXT || src_r == SRC_BUS)) || one_shot_bus_trigger;

	// ------------------------------------------------------------
	// delay and measurement sequence
	// ------------------------------------------------------------
	always_comb
	begin
		state_nxt = state_r;
		dcnt_nxt  = dcnt_r;
		start_nxt = 1'b0;
		res_nxt   = res_r;
		mcnt_nxt  = mcnt_r;
		done_evt  = 1'b0;
		unique case (state_r)
			ST_IDLE:
				if (trigger_source_select)
				begin
					state_nxt = ST_DELAY;
					dcnt_nxt  = cv.cyc;
				end
			ST_DELAY:
				if (dcnt_r == '0)
				begin
					start_nxt = 1'b1;
					state_nxt = ST_MEAS;
				end
				else
					dcnt_nxt = dcnt_r - 1'b1;
			ST_MEAS:
				if (I_MEAS_DONE)
				begin
					done_evt  = 1'b1;
					res_nxt   = I_CMP_PASS;
					mcnt_nxt  = mcnt_r + 1'b1;
					state_nxt = ST_IDLE;
				end
		endcase
		busy_nxt = (state_nxt != ST_IDLE);
	end

	always_ff @(posedge I_MCLK)
	begin
		if (I_SRST)
		begin
			state_r <= ST_IDLE;
			dcnt_r  <= '0;
			start_r <= 1'b0;
			res_r   <= '0;
			mcnt_r  <= '0;
			busy_r  <= 1'b0;
		end
		else
		begin
			state_r <= state_nxt;
			dcnt_r  <= dcnt_nxt;
			start_r <= start_nxt;
			res_r   <= res_nxt;
			mcnt_r  <= mcnt_nxt;
			busy_r  <= busy_nxt;
		end
	end

	// ------------------------------------------------------------
	// relay channels
	// ------------------------------------------------------------
	// independent channels
	for (genvar i = 0; i < CH_COUNT; i++)
	begin : g_ch
		logic [MODE_W-1:0] mode;
		logic              fail_m, steady_m, pulse_m, match;
		logic              relay_nxt;
		logic [PW-1:0]     pcnt_nxt;

		assign mode     = mode_r[MODE_W*i +: MODE_W];
		// mode decode, unknown codes act as off
		assign fail_m   = (mode == MODE_FAIL_ST) || (mode == MODE_FAIL_PL);
		assign steady_m = (mode == MODE_FAIL_ST) || (mode == MODE_PASS_ST);
		assign pulse_m  = (mode == MODE_FAIL_PL) || (mode == MODE_PASS_PL);
		assign match    = fail_m ? !I_CMP_PASS[i] : I_CMP_PASS[i];

		always_comb
		begin
			relay_nxt = relay_r[i];
			pcnt_nxt  = pcnt_r[i];
			if (!steady_m && !pulse_m)
			begin
				relay_nxt = 1'b0;
				pcnt_nxt  = '0;
			end
			else if (done_evt)
			begin
				relay_nxt = match;
				pcnt_nxt  = (pulse_m && match) ? PW'(PULSE_CYCLES - 1) : '0;
			end
			else if (pulse_m)
			begin
				if (pcnt_r[i] == '0)
					relay_nxt = 1'b0;
				else
					pcnt_nxt = pcnt_r[i] - 1'b1;
			end
		end

		always_ff @(posedge I_MCLK)
		begin
			if (I_SRST)
			begin
				relay_r[i] <= 1'b0;
				pcnt_r[i]  <= '0;
			end
			else
			begin
				relay_r[i] <= relay_nxt;
				pcnt_r[i]  <= pcnt_nxt;
			end
		end

		// relay shorts the judged terminal pair
		assign relay_vec[i] = relay_r[i];

		a_steady_track: assert property (
			@(posedge I_MCLK) disable iff (I_SRST)
			done_evt && steady_m |=> relay_r[i] == $past(match))
			else $error("steady relay does not follow result");
		a_pulse_load: assert property (
			@(posedge I_MCLK) disable iff (I_SRST)
			done_evt && pulse_m && match |=> relay_r[i] && pcnt_r[i] == PULSE_CYCLES - 1)
			else $error("pulse not started with full width");
		a_pulse_end: assert property (
			@(posedge I_MCLK) disable iff (I_SRST)
			pulse_m && relay_r[i] && pcnt_r[i] == '0 && !done_evt && $stable(mode)
			|=> !relay_r[i])
			else $error("pulse relay held past its width");
		a_off_open: assert property (
			@(posedge I_MCLK) disable iff (I_SRST)
			!steady_m && !pulse_m |=> !relay_r[i])
			else $error("off channel relay closed");
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign O_HREADYOUT             = ready_r;
	assign O_HRDATA                = rdata_r;
	assign O_HRESP                 = resp_r;
	assign O_MEAS_START            = start_r;
	assign O_BUSY                  = busy_r;
	assign O_OUTPUT_CHANNEL_1_TO_4 = relay_vec;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge I_MCLK); endclocking
	default disable iff (I_SRST);

	sequence s_trigger_source_select_taken;
		state_r == ST_IDLE ##1 state_r == ST_DELAY;
	endsequence

	sequence s_delay_end;
		state_r == ST_DELAY && dcnt_r == '0;
	endsequence

	a_src_internal: assert property (
		state_r == ST_IDLE && src_r == SRC_INT |=> state_r == ST_DELAY)
		else $error("internal source did not retrigger");
	a_delay_bound: assert property (
		s_trigger_source_select_taken |-> dcnt_r <= DELAY_MAX_CYCLES)
		else $error("delay count beyond sixty seconds");
	a_bus_trigger: assert property (
		state_r == ST_IDLE && one_shot_bus_trigger |=> state_r == ST_DELAY)
		else $error("bus trigger not taken");
	a_ext_edges: assert property (
		state_r == ST_IDLE && src_r == SRC_EXT && !ext_fall && !one_shot_bus_trigger
		|=> state_r == ST_IDLE)
		else $error("trigger without falling edge");
	a_ext_gate: assert property (
		state_r == ST_IDLE && src_r == SRC_MAN && !key_rise && !one_shot_bus_trigger
		|=> state_r == ST_IDLE)
		else $error("external edge taken in manual source");
	a_delay_start: assert property (
		s_delay_end |=> start_r && state_r == ST_MEAS ##1 !start_r)
		else $error("measurement start not single after delay");
	a_busy_count: assert property (
		state_r == ST_DELAY && dcnt_r != '0
		|=> state_r == ST_DELAY && dcnt_r == $past(dcnt_r) - 1'b1)
		else $error("delay disturbed while busy");
	a_meas_hold: assert property (
		state_r == ST_MEAS && !I_MEAS_DONE |=> state_r == ST_MEAS && !start_r)
		else $error("second start during measurement");

endmodule

/* File: bench/meas_engine_model.sv */
// measurement engine model answering start pulses with done and results
`timescale 1ns/1ps
module meas_engine_model
(
	// clock
	input  wire logic       i_clk,
	// request and setup
	input  wire logic       i_start,
	input  wire logic [3:0] i_pass_pat,
	input  wire logic [7:0] i_latency,
	// answer
	output logic            o_done,
	output logic [3:0]      o_pass
);
	// ------------------------------------------------------------
	// one done pulse per start, results valid with done only
	// ------------------------------------------------------------
	initial
	begin
		o_done = 1'b0;
		o_pass = 4'h0;
	end
	always @(posedge i_clk)
	begin
		if (i_start === 1'b1)
		begin
			repeat (i_latency) @(posedge i_clk);
			o_done <= 1'b1;
			o_pass <= i_pass_pat;
			@(posedge i_clk);
			o_done <= 1'b0;
			// stale results are not held
			o_pass <= ~i_pass_pat;
		end
	end
endmodule

/* File: bench/tb_handler_trigger_output.sv */
// self-checking bench for the handler trigger and relay block
`timescale 1ns/1ps
module tb_handler_trigger_output;
	import handler_pkg::*;
	localparam int PULSE_SIM = 10;
	localparam int DMAX_SIM  = 200;
	// ------------------------------------------------------------
	// signals
	// ------------------------------------------------------------
	logic        clk;
	logic        srst;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	logic        hreadyout;
	logic [31:0] hrdata;
	logic        hresp;
	logic        external_trigger_n_n;
	logic        man_key;
	logic [3:0]  relays;
	logic        meas_start;
	logic        meas_done;
	logic [3:0]  cmp_pass;
	logic        busy;
	logic [3:0]  pass_pat;
	logic [7:0]  latency;
	logic [31:0] rd;
	int          bad_count  = 0;
	int          n_compared = 0;
	int          start_cnt  = 0;
	// ------------------------------------------------------------
	// design and partner
	// ------------------------------------------------------------
	handler_trigger_output #(
		.CH_COUNT         (4),
		.PULSE_CYCLES     (PULSE_SIM),
		.DELAY_MAX_CYCLES (CYC_W'(DMAX_SIM))
	) u_dut (
		.I_MCLK                  (clk),
		.I_SRST                  (srst),
		.I_HSEL                  (hsel),
		.I_HADDR                 (haddr),
		.I_HTRANS                (htrans),
		.I_HWRITE                (hwrite),
		.I_HSIZE                 (hsize),
		.I_HWDATA                (hwdata),
		.I_HREADY                (hreadyout),
		.O_HREADYOUT             (hreadyout),
		.O_HRDATA                (hrdata),
		.O_HRESP                 (hresp),
		.I_EXTERNAL_TRIGGER_N    (external_trigger_n_n),
		.I_MANUAL_KEY            (man_key),
		.O_OUTPUT_CHANNEL_1_TO_4 (relays),
		.O_MEAS_START            (meas_start),
		.I_MEAS_DONE             (meas_done),
		.I_CMP_PASS              (cmp_pass),
		.O_BUSY                  (busy)
	);
	meas_engine_model u_engine (
		.i_clk      (clk),
		.i_start    (meas_start),
		.i_pass_pat (pass_pat),
		.i_latency  (latency),
		.o_done     (meas_done),
		.o_pass     (cmp_pass)
	);
	// ------------------------------------------------------------
	// clock, start counter, watchdog
	// ------------------------------------------------------------
	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	always @(posedge clk)
		if (meas_start === 1'b1)
			start_cnt <= start_cnt + 1;
	initial
	begin
		repeat (20000) @(posedge clk);
		bad_count++;
		complete_run;
	end
	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic complete_run;
		$display("counts: compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic edges(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic wait_ready;
		@(posedge clk);
		while (hreadyout !== 1'b1)
			@(posedge clk);
	endtask
	task automatic ahb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
		hsel   <= 1'b1;
		htrans <= 2'h2;
		haddr  <= {22'h0, idx, 2'b00};
		hwrite <= wr;
		hsize  <= 3'h2;
		wait_ready;
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		wait_ready;
		rd = hrdata;
	endtask
	task automatic wait_idle;
		while (busy !== 1'b0)
			@(posedge clk);
	endtask
	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_regs;
		for (int s = 3; s >= 0; s--)
		begin
			ahb(1'b1, IDX_TRIGGER_SOURCE_SELECT_SRC, s);
			ahb(1'b0, IDX_TRIGGER_SOURCE_SELECT_SRC, 32'h0);
			check("source readback", rd, s);
		end
		ahb(1'b1, IDX_TRIGGER_SOURCE_SELECT_SRC, 32'h5);
		wait_idle;
		ahb(1'b1, IDX_DELAY, 32'h4270_0000);
		ahb(1'b0, IDX_DELAY, 32'h0);
		check("delay readback", rd, 32'h4270_0000);
		ahb(1'b0, IDX_ONE_SHOT_BUS_TRIGGER, 32'h0);
		check("bus trigger read", rd, 32'h0);
		ahb(1'b0, 8'h40, 32'h0);
		check("unmapped read", rd, 32'h0);
		check("bus response", {31'h0, hresp}, 32'h0);
	endtask
	task automatic t_delay(input logic [31:0] f, input int d);
		int c0;
		int nb;
		int ns;
		nb = 0;
		ns = 0;
		ahb(1'b1, IDX_DELAY, f);
		c0 = start_cnt;
		ahb(1'b1, IDX_ONE_SHOT_BUS_TRIGGER, 32'hffff_ff00);
		for (int k = 1; k <= 400 && ns == 0; k++)
		begin
			@(posedge clk);
			if (busy === 1'b1 && nb == 0)
				nb = k;
			if (meas_start === 1'b1)
				ns = k;
		end
		check("trigger answer", nb, 1);
		check("delay to start", ns - nb, d + 1);
		ahb(1'b1, IDX_ONE_SHOT_BUS_TRIGGER, 32'h0);
		external_trigger_n_n <= 1'b0;
		wait_idle;
		external_trigger_n_n <= 1'b1;
		edges(DMAX_SIM + 10);
		check("one start per trigger", start_cnt - c0, 1);
	endtask
	task automatic t_ext(input logic [7:0] src, input int exp);
		int c0;
		ahb(1'b1, IDX_TRIGGER_SOURCE_SELECT_SRC, {24'h0, src});
		c0 = start_cnt;
		external_trigger_n_n <= 1'b0;
		edges(60);
		external_trigger_n_n <= 1'b1;
		edges(60);
		wait_idle;
		check("pin starts", start_cnt - c0, exp);
	endtask
	task automatic t_sources;
		int c0;
		ahb(1'b1, IDX_TRIGGER_SOURCE_SELECT_SRC, 32'h1);
		c0 = start_cnt;
		man_key <= 1'b1;
		edges(60);
		man_key <= 1'b0;
		wait_idle;
		check("manual start", start_cnt - c0, 1);
		ahb(1'b1, IDX_TRIGGER_SOURCE_SELECT_SRC, 32'h0);
		c0 = start_cnt;
		edges(100);
		ahb(1'b1, IDX_TRIGGER_SOURCE_SELECT_SRC, 32'h5);
		wait_idle;
		check("internal restarts", 32'(start_cnt - c0 >= 2), 1);
	endtask
	task automatic t_relay(input logic [31:0] modes, input logic [3:0] pat,
			input logic [3:0] first, input logic [3:0] after);
		ahb(1'b1, IDX_CH_MODE, modes);
		pass_pat <= pat;
		ahb(1'b1, IDX_ONE_SHOT_BUS_TRIGGER, 32'h0);
		edges(1);
		for (int k = 0; k < 400 && busy !== 1'b0; k++)
		begin
			@(posedge clk);
			#1;
		end
		check("relays at result", relays, first);
		edges(PULSE_SIM - 1);
		#1;
		check("relays pulse end", relays, first);
		edges(1);
		#1;
		check("relays after pulse", relays, after);
		ahb(1'b0, IDX_STATUS, 32'h0);
		check("status word", {20'h0, rd[11:0]}, {20'h0, pat, after, 4'h0});
	endtask
	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial
	begin
		srst       = 1'b1;
		hsel       = 1'b0;
		haddr      = 32'h0;
		htrans     = 2'h0;
		hwrite     = 1'b0;
		hsize      = 3'h2;
		hwdata     = 32'h0;
		external_trigger_n_n = 1'b1;
		man_key    = 1'b0;
		pass_pat   = 4'h0;
		latency    = 8'd20;
		edges(16);
		srst <= 1'b0;
		edges(1);
		t_regs;
		t_delay(32'h0000_0000, 0);
		t_delay(32'h3400_0000, 14);
		t_delay(32'h4270_0000, DMAX_SIM);
		ahb(1'b1, IDX_DELAY, 32'h0);
		t_ext(8'h1, 0);
		t_ext(8'h2, 1);
		t_ext(8'h3, 1);
		t_ext(8'h5, 0);
		t_sources;
		t_relay({20'h0, MODE_PASS_PL, MODE_FAIL_PL, MODE_PASS_ST, MODE_FAIL_ST},
			4'b1010, 4'b1111, 4'b0011);
		t_relay({20'h0, MODE_PASS_PL, MODE_FAIL_PL, MODE_PASS_ST, MODE_FAIL_ST},
			4'b0101, 4'b0000, 4'b0000);
		t_relay({20'h0, MODE_OFF, MODE_OFF, MODE_OFF, MODE_OFF},
			4'b1010, 4'b0000, 4'b0000);
		complete_run;
	end
endmodule
